// ==== spcf_pkg.sv ====
// Purpose: Shared constants for the serial memory command framing link.
// Assumes: Serial mode 0, most significant bit first, byte-oriented frames.
// Notes:   Register addresses sit in the 10-bit serial address space.
package spcf_pkg;
  // Byte and header layout.
  localparam int          BYTE_W      = 8;
  localparam int          RW_BIT      = 2;
  localparam logic        RW_READ_DEF = 1'b1;
  // Memory map defaults.
  localparam logic [9:0]  PARAM_BASE_DEF  = 10'h000;
  localparam int          PARAM_DEPTH_DEF = 256;
  localparam logic [9:0]  PROG_BASE_DEF   = 10'h200;
  localparam int          PROG_DEPTH_DEF  = 512;
  localparam logic [9:0]  ADDR_CTRL1  = 10'h100;
  localparam logic [9:0]  ADDR_CTRL2  = 10'h101;
  localparam logic [9:0]  ADDR_VOL    = 10'h102;
  localparam logic [9:0]  ADDR_CAPRD  = 10'h103;
  localparam logic [9:0]  ADDR_CAPSET = 10'h105;
  localparam logic [9:0]  ADDR_SERSET = 10'h107;
  localparam logic [9:0]  ADDR_SAFE   = 10'h109;
  localparam int          SAFE_SLOTS  = 5;
  // Target kinds of an address.
  localparam logic [3:0]  K_NONE = 4'h0, K_PARAM = 4'h1, K_PROG = 4'h2, K_CTRL1 = 4'h3;
  localparam logic [3:0]  K_CTRL2 = 4'h4, K_VOL = 4'h5, K_CAPRD = 4'h6, K_CAPSET = 4'h7;
  localparam logic [3:0]  K_SERSET = 4'h8, K_SAFE = 4'h9;
  // Data bytes after the header, per target.
  localparam logic [2:0]  NB_PARAM = 3'h3, NB_PROG = 3'h5, NB_CTRL1_WR = 3'h2;
  localparam logic [2:0]  NB_CTRL1_RD = 3'h1, NB_CTRL2 = 3'h2, NB_VOL = 3'h3;
  localparam logic [2:0]  NB_SETUP = 3'h2, NB_CAPRD = 3'h4, NB_SAFE = 3'h4;
  // Field widths and positions.
  localparam int          PARAM_W = 22;
  localparam int          PROG_W  = 35;
  localparam int          CTRL1_W = 12;
  localparam int          CTRL2_W = 10;
  localparam int          SETUP_W = 11;
  localparam int          CAP_W   = 24;
  localparam int          SAFE_W  = 30;
  localparam int          SL_GO_BIT_DEF = 4;
  localparam logic [11:0] CTRL1_RST = 12'h000;
  // Host register offsets and bits.
  localparam logic [3:0]  HR_CTRL = 4'h0, HR_HDR = 4'h4, HR_DATA = 4'h8, HR_STAT = 4'hc;
  localparam int          HDR_RW_BIT = 10;
  // Host link clock half period.
  localparam int          CLK_NS        = 8;
  localparam int          SCLK_HALF_NS  = 128;
  localparam int          SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ==== spcf_link_if.sv ====
// Purpose: Serial link between the host controller and the memory device end.
// Assumes: Returning data line is pulled high when nobody drives it.
// Notes:   The wire level is resolved here from the device output enable.
`timescale 1ns/1ps
`default_nettype none
interface spcf_link_if;
  logic sclk;      // Link clock, made by the host.
  logic cs_n;      // Frame select, active low.
  logic mosi;      // Host to device data.
  logic miso_o;    // Device data output.
  logic miso_oe;   // Device drives the returning line.
  logic miso;      // Resolved returning line.

  // Pull-up when the device releases the line.
  assign miso = miso_oe ? miso_o : 1'b1;

  modport host (output sclk, output cs_n, output mosi, input miso);
  modport device (input sclk, input cs_n, input mosi, output miso_o, output miso_oe);
endinterface
`default_nettype wire

// ==== spcf_sync3.sv ====
// Purpose: Brings a pin level into the clock domain.
// Assumes: Input is asynchronous to clk_in.
// Notes:   The output changes only when the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module spcf_sync3 #(
  parameter logic RST_LEVEL = 1'b0
) (
  input  wire logic clk_in,     // System clock.
  input  wire logic sys_rst_in, // Synchronous reset, active high.
  input  wire logic d_in,       // Asynchronous pin level.
  output var  logic q_out       // Filtered level.
);
  logic [2:0] stg_reg;

  // Three stages; only the last two feed the filtered level.
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      stg_reg <= {3{RST_LEVEL}};
      q_out   <= RST_LEVEL;
    end
    else
    begin
      stg_reg <= {stg_reg[1:0], d_in};
      if (stg_reg[1] == stg_reg[2])
      begin
        q_out <= stg_reg[2];
      end
    end
  end
endmodule
`default_nettype wire

// ==== spcf_device.sv ====
// Purpose: Device end of the serial link: frames commands into memories and registers.
// Assumes: Mode 0 link, header then zero-padded data bytes, most significant first.
// Notes:   Link pins are sampled by clk_in; sclk must stay well below clk_in/6.
// Notes on behaviour
// - Data fields padded to whole bytes.
// - Parameter word: three bytes, two zero bits.
// - Program word: five bytes, five zero bits.
// - Two header bytes: rw, ten-bit address.
// - Address and read/write bit set the data length.
// - Single writes span four to seven bytes.
// - Memory burst words go to next address.
// - Both memories read, write and burst.
// - First control write: twelve bits, two bytes.
// - First control read: two status bits.
// - Second control write: ten bits, two bytes.
// - Volume write: 22 bits, three bytes.
// - Capture setup: step and source select.
// - Step names program counter for capture.
// - Serial-out setups share capture setup format.
// - Readback: zero byte, then 24 bits.
// - Safeload: target byte, then parameter word.
// - Source select codes 00 to 11.
// - Safeload done bit clears on read.
// - Capture setups at addresses 261 to 264.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module spcf_device
  import spcf_pkg::*;
#(
  parameter logic       RW_READ     = spcf_pkg::RW_READ_DEF,
  parameter logic [9:0] PARAM_BASE  = spcf_pkg::PARAM_BASE_DEF,
  parameter int         PARAM_DEPTH = spcf_pkg::PARAM_DEPTH_DEF,
  parameter logic [9:0] PROG_BASE   = spcf_pkg::PROG_BASE_DEF,
  parameter int         PROG_DEPTH  = spcf_pkg::PROG_DEPTH_DEF,
  parameter int         SL_GO_BIT   = spcf_pkg::SL_GO_BIT_DEF
) (
  input  wire logic                       clk_in,             // System clock.
  input  wire logic                       sys_rst_in,         // Synchronous reset.
  spcf_link_if.device                     link,               // Serial link.
  input  wire logic                       core_halted_in,     // Core shut down status.
  input  wire logic                       safeload_window_in, // Core has a free slot.
  input  wire logic [1:0][23:0]           cap_data_in,        // Captured values.
  input  wire logic [$clog2(PARAM_DEPTH)-1:0] param_rd_addr_in, // Core parameter address.
  input  wire logic [$clog2(PROG_DEPTH)-1:0]  prog_rd_addr_in,  // Core program address.
  output logic      [21:0]                param_rd_data_out,  // Parameter word.
  output logic      [34:0]                prog_rd_data_out,   // Program word.
  output logic      [11:0]                control_one_out,    // First control register.
  output logic      [9:0]                 control_two_out,    // Second control register.
  output logic      [21:0]                output_volume_out,  // Volume value.
  output logic      [1:0][10:0]           capture_setup_out,  // Step and source select.
  output logic      [1:0][10:0]           serial_capture_setup_out // Serial-out setups.
);
  localparam int PA_W = $clog2(PARAM_DEPTH);
  localparam int PG_W = $clog2(PROG_DEPTH);

  typedef struct packed {
    logic                          sclk_prev;
    logic [2:0]                    bitn;
    logic [2:0]                    bytew;
    logic [1:0]                    hdrn;
    logic                          rd;
    logic [9:0]                    addr;
    logic [3:0]                    kind;
    logic [2:0]                    nb;
    logic [7:0]                    rxb;
    logic [31:0]                   acc;
    logic [39:0]                   tx;
    logic                          miso;
    logic                          miso_oe;
    logic [CTRL1_W-1:0]            ctrl1;
    logic [CTRL2_W-1:0]            ctrl2;
    logic [PARAM_W-1:0]            vol;
    logic [1:0][SETUP_W-1:0]       capset;
    logic [1:0][SETUP_W-1:0]       serset;
    logic                          sl_done;
    logic                          sl_busy;
    logic [2:0]                    sl_idx;
    logic [SAFE_SLOTS-1:0]         sl_pend;
    logic [SAFE_SLOTS-1:0][SAFE_W-1:0] sl_regs;
    logic [PARAM_W-1:0]            prd;
    logic [PROG_W-1:0]             pgd;
    logic                          we_p;
    logic                          we_g;
    logic [9:0]                    wa;
    logic [39:0]                   wd;
  } spcf_dev_st_t;

  spcf_dev_st_t       st_reg;
  spcf_dev_st_t       st_next;
  logic [PARAM_W-1:0] param_mem [PARAM_DEPTH];
  logic [PROG_W-1:0]  prog_mem [PROG_DEPTH];
  logic               sclk_l;
  logic               cs_l;
  logic               mosi_l;
  logic [7:0]         b;
  logic [39:0]        w;
  logic [9:0]         na;

  // Pin synchronisers.
  spcf_sync3 #(.RST_LEVEL(1'b0)) u_sclk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .d_in(link.sclk), .q_out(sclk_l));
  spcf_sync3 #(.RST_LEVEL(1'b1)) u_cs (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .d_in(link.cs_n), .q_out(cs_l));
  spcf_sync3 #(.RST_LEVEL(1'b0)) u_mosi (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .d_in(link.mosi), .q_out(mosi_l));

  // Maps an address to its target kind.
  function automatic logic [3:0] region(input logic [9:0] a);
    if ({22'h0, a} >= PARAM_BASE && {22'h0, a} < {22'h0, PARAM_BASE} + PARAM_DEPTH)
      return K_PARAM;
    if ({22'h0, a} >= PROG_BASE && {22'h0, a} < {22'h0, PROG_BASE} + PROG_DEPTH)
      return K_PROG;
    if (a == ADDR_CTRL1) return K_CTRL1;
    if (a == ADDR_CTRL2) return K_CTRL2;
    if (a == ADDR_VOL) return K_VOL;
    if (a - ADDR_CAPRD < 10'h2) return K_CAPRD;
    if (a - ADDR_CAPSET < 10'h2) return K_CAPSET;
    if (a - ADDR_SERSET < 10'h2) return K_SERSET;
    if (a - ADDR_SAFE < 10'(SAFE_SLOTS)) return K_SAFE;
    return K_NONE;
  endfunction

  // Data byte count per target and direction; zero means ignore.
  function automatic logic [2:0] len(input logic [3:0] k, input logic r);
    case (k)
      K_PARAM:  return NB_PARAM;
      K_PROG:   return NB_PROG;
      K_CTRL1:  return r ? NB_CTRL1_RD : NB_CTRL1_WR;
      K_CTRL2:  return r ? 3'h0 : NB_CTRL2;
      K_VOL:    return r ? 3'h0 : NB_VOL;
      K_CAPRD:  return r ? NB_CAPRD : 3'h0;
      K_CAPSET: return r ? 3'h0 : NB_SETUP;
      K_SERSET: return r ? 3'h0 : NB_SETUP;
      K_SAFE:   return r ? 3'h0 : NB_SAFE;
      default:  return 3'h0;
    endcase
  endfunction

  // Read word of a target, left aligned to its byte count.
  function automatic logic [39:0] rd_word(input logic [3:0] k, input logic [9:0] a,
                                          input logic [2:0] n, input logic done);
    logic [39:0] v;
    v = 40'h0;
    case (k)
      K_PARAM: v = {18'h0, param_mem[PA_W'(a - PARAM_BASE)]};
      K_PROG:  v = {5'h0, prog_mem[PG_W'(a - PROG_BASE)]};
      K_CTRL1: v = {38'h0, core_halted_in, done};
      K_CAPRD: v = {16'h0, cap_data_in[a[0] ^ ADDR_CAPRD[0]]};
      default: v = 40'h0;
    endcase
    return v << {3'(3'h5 - n), 3'h0};
  endfunction

  always_comb
  begin
    st_next = st_reg;
    st_next.we_p = 1'b0;
    st_next.we_g = 1'b0;
    st_next.sclk_prev = sclk_l;
    b = {st_reg.rxb[6:0], mosi_l};
    w = {st_reg.acc, b};
    na = st_reg.addr + 10'h1;
    st_next.prd = param_mem[param_rd_addr_in];
    st_next.pgd = prog_mem[prog_rd_addr_in];
    if (cs_l)
    begin
      st_next.bitn = 3'h0;
      st_next.bytew = 3'h0;
      st_next.hdrn = 2'h0;
      st_next.nb = 3'h0;
      st_next.miso = 1'b0;
      st_next.miso_oe = 1'b0;
    end
    else if (sclk_l && !st_reg.sclk_prev)
    begin
      st_next.miso_oe = 1'b1;
      st_next.rxb = b;
      st_next.bitn = st_reg.bitn + 3'h1;
      if (st_reg.bitn == 3'h7)
      begin
        if (st_reg.hdrn == 2'h0)
        begin
          st_next.rd = (b[RW_BIT] == RW_READ);
          st_next.addr = {b[1:0], 8'h0};
          st_next.hdrn = 2'h1;
        end
        else if (st_reg.hdrn == 2'h1)
        begin
          st_next.addr = {st_reg.addr[9:8], b};
          st_next.kind = region({st_reg.addr[9:8], b});
          st_next.nb = len(st_next.kind, st_reg.rd);
          st_next.hdrn = 2'h2;
          st_next.acc = 32'h0;
          st_next.tx = rd_word(st_next.kind, st_next.addr, st_next.nb, st_reg.sl_done);
          if (st_reg.rd && st_next.kind == K_CTRL1)
          begin
            st_next.sl_done = 1'b0;
          end
        end
        else if (st_reg.nb != 3'h0)
        begin
          st_next.acc = w[31:0];
          st_next.bytew = st_reg.bytew + 3'h1;
          if (st_reg.bytew == st_reg.nb - 3'h1)
          begin
            st_next.bytew = 3'h0;
            st_next.acc = 32'h0;
            if (!st_reg.rd)
            begin
              case (st_reg.kind)
                K_PARAM: begin st_next.we_p = 1'b1; st_next.wa = st_reg.addr; st_next.wd = w; end
                K_PROG:  begin st_next.we_g = 1'b1; st_next.wa = st_reg.addr; st_next.wd = w; end
                K_CTRL1: st_next.ctrl1 = w[CTRL1_W-1:0];
                K_CTRL2: st_next.ctrl2 = w[CTRL2_W-1:0];
                K_VOL:   st_next.vol = w[PARAM_W-1:0];
                K_CAPSET: st_next.capset[st_reg.addr[0] ^ ADDR_CAPSET[0]] = w[SETUP_W-1:0];
                K_SERSET: st_next.serset[st_reg.addr[0] ^ ADDR_SERSET[0]] = w[SETUP_W-1:0];
                K_SAFE:
                begin
                  // Target byte sits above the padded word; the two pad bits are dropped.
                  st_next.sl_regs[3'(st_reg.addr - ADDR_SAFE)] = {w[31:24], w[PARAM_W-1:0]};
                  st_next.sl_pend[3'(st_reg.addr - ADDR_SAFE)] = 1'b1;
                end
                default: st_next.acc = 32'h0;
              endcase
            end
            if (st_reg.kind == K_PARAM || st_reg.kind == K_PROG)
            begin
              st_next.addr = na;
              st_next.kind = region(na);
              st_next.nb = len(st_next.kind, st_reg.rd);
              st_next.tx = rd_word(st_next.kind, na, st_next.nb, st_reg.sl_done);
            end
            else
            begin
              st_next.nb = 3'h0;
            end
          end
        end
      end
    end
    else if (!sclk_l && st_reg.sclk_prev && st_reg.hdrn == 2'h2 && st_reg.rd)
    begin
      st_next.miso_oe = 1'b1;
      st_next.miso = st_reg.tx[39];
      st_next.tx = {st_reg.tx[38:0], 1'b0};
    end
    else
    begin
      st_next.miso_oe = 1'b1;
    end
    // Safeload start when the core offers a free slot.
    if (st_reg.ctrl1[SL_GO_BIT] && safeload_window_in && !st_reg.sl_busy)
    begin
      st_next.sl_busy = 1'b1;
      st_next.sl_idx = 3'h0;
      st_next.ctrl1[SL_GO_BIT] = 1'b0;
    end
    else if (st_reg.sl_busy && !st_next.we_p)
    begin
      if (st_reg.sl_pend[st_reg.sl_idx])
      begin
        st_next.we_p = 1'b1;
        st_next.wa = {2'h0, st_reg.sl_regs[st_reg.sl_idx][SAFE_W-1:PARAM_W]} + PARAM_BASE;
        st_next.wd = {18'h0, st_reg.sl_regs[st_reg.sl_idx][PARAM_W-1:0]};
        st_next.sl_pend[st_reg.sl_idx] = 1'b0;
      end
      st_next.sl_idx = st_reg.sl_idx + 3'h1;
      if (st_reg.sl_idx == 3'(SAFE_SLOTS - 1))
      begin
        st_next.sl_busy = 1'b0;
        st_next.sl_done = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      st_reg <= '0;
      st_reg.ctrl1 <= CTRL1_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Memory write port.
  always_ff @(posedge clk_in)
  begin
    if (st_reg.we_p)
    begin
      param_mem[PA_W'(st_reg.wa - PARAM_BASE)] <= st_reg.wd[PARAM_W-1:0];
    end
    if (st_reg.we_g)
    begin
      prog_mem[PG_W'(st_reg.wa - PROG_BASE)] <= st_reg.wd[PROG_W-1:0];
    end
  end

  // Outputs straight from the state register.
  assign link.miso_o = st_reg.miso;
  assign link.miso_oe = st_reg.miso_oe;
  assign param_rd_data_out = st_reg.prd;
  assign prog_rd_data_out = st_reg.pgd;
  assign control_one_out = st_reg.ctrl1;
  assign control_two_out = st_reg.ctrl2;
  assign output_volume_out = st_reg.vol;
  assign capture_setup_out = st_reg.capset;
  assign serial_capture_setup_out = st_reg.serset;
endmodule
`default_nettype wire

// ==== spcf_host.sv ====
// Purpose: Host end: sends headers and data bytes on the serial link.
// Assumes: Software frames commands; this end moves bytes and the select.
// Notes:   Writes while busy are ignored; poll the status busy bit.
`timescale 1ns/1ps
`default_nettype none
module spcf_host
  import spcf_pkg::*;
#(
  parameter int HALF_CYC = spcf_pkg::SCLK_HALF_CYC
) (
  input  wire logic        clk_in,     // System clock.
  input  wire logic        sys_rst_in, // Synchronous reset.
  spcf_link_if.host        link,       // Serial link.
  input  wire logic [3:0]  addr_in,    // Register offset.
  input  wire logic [31:0] wdata_in,   // Write data.
  input  wire logic        wr_in,      // Write strobe.
  input  wire logic        rd_in,      // Read strobe.
  output logic      [31:0] rdata_out   // Read data, one cycle after the strobe.
);
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SHIFT = 2'b10} spcf_hst_e_t;

  typedef struct packed {
    spcf_hst_e_t st;
    logic [7:0]  div;
    logic [4:0]  nbits;
    logic [15:0] sh;
    logic [7:0]  rx;
    logic        sclk;
    logic        cs_n;
    logic        mosi;
    logic [31:0] rdata;
  } spcf_hst_st_t;

  spcf_hst_st_t st_reg;
  spcf_hst_st_t st_next;
  logic         miso_l;

  spcf_sync3 #(.RST_LEVEL(1'b1)) u_miso (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .d_in(link.miso), .q_out(miso_l));

  // Register access and byte shifter.
  always_comb
  begin
    st_next = st_reg;
    st_next.rdata = 32'h0;
    if (rd_in)
    begin
      case (addr_in)
        HR_CTRL: st_next.rdata = {31'h0, ~st_reg.cs_n};
        HR_DATA: st_next.rdata = {24'h0, st_reg.rx};
        HR_STAT: st_next.rdata = {30'h0, ~st_reg.cs_n, st_reg.st == ST_SHIFT};
        default: st_next.rdata = 32'h0;
      endcase
    end
    case (st_reg.st)
      ST_IDLE:
      begin
        st_next.sclk = 1'b0;
        st_next.div = 8'h0;
        if (wr_in && addr_in == HR_CTRL)
        begin
          st_next.cs_n = ~wdata_in[0];
        end
        else if (wr_in && addr_in == HR_HDR)
        begin
          st_next.sh = {5'h0, wdata_in[HDR_RW_BIT], wdata_in[9:0]};
          st_next.nbits = 5'd16;
          st_next.mosi = 1'b0;
          st_next.st = ST_SHIFT;
        end
        else if (wr_in && addr_in == HR_DATA)
        begin
          st_next.sh = {wdata_in[7:0], 8'h0};
          st_next.nbits = 5'd8;
          st_next.mosi = wdata_in[7];
          st_next.st = ST_SHIFT;
        end
      end
      ST_SHIFT:
      begin
        st_next.div = st_reg.div + 8'h1;
        if (st_reg.div == 8'(HALF_CYC - 1))
        begin
          st_next.div = 8'h0;
          st_next.sclk = ~st_reg.sclk;
          if (!st_reg.sclk)
          begin
            st_next.rx = {st_reg.rx[6:0], miso_l};
          end
          else
          begin
            st_next.sh = {st_reg.sh[14:0], 1'b0};
            st_next.mosi = st_reg.sh[14];
            st_next.nbits = st_reg.nbits - 5'h1;
            if (st_reg.nbits == 5'h1)
            begin
              st_next.st = ST_IDLE;
            end
          end
        end
      end
      default: st_next.st = ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      st_reg <= '{st: ST_IDLE, cs_n: 1'b1, default: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Link and bus outputs from the state register.
  assign link.sclk = st_reg.sclk;
  assign link.cs_n = st_reg.cs_n;
  assign link.mosi = st_reg.mosi;
  assign rdata_out = st_reg.rdata;
endmodule
`default_nettype wire

// ==== spcf_checker.sv ====
// Purpose: Watches the serial link between the host end and the device end.
// Assumes: Mode 0 link, both ends leave reset together.
// Notes:   The link clock half period is at least eight system cycles.
`timescale 1ns/1ps
`default_nettype none
module spcf_checker (
  input wire logic clk_in,     // System clock.
  input wire logic sys_rst_in, // Reset, active high.
  input wire logic sclk_in,    // Link clock.
  input wire logic cs_n_in,    // Frame select.
  input wire logic mosi_in,    // Host data.
  input wire logic miso_o_in,  // Device data.
  input wire logic miso_oe_in, // Device enable.
  input wire logic miso_in     // Resolved line.
);
  logic [7:0] bits_reg;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Counts link clock rises inside a frame.
  always_ff @(posedge clk_in)
    if (sys_rst_in || cs_n_in)
      bits_reg <= 8'h00;
    else if ($rose(sclk_in) && bits_reg != 8'hff)
      bits_reg <= bits_reg + 8'h01;
  idle_clock_low_a:
    assert property (cs_n_in |-> !sclk_in) else $error("link clock high while deselected");
  select_edge_quiet_a:
    assert property ($changed(cs_n_in) |-> !sclk_in && !$past(sclk_in))
      else $error("select moved");
  clock_high_hold_a:
    assert property ($rose(sclk_in) |-> sclk_in [*8]) else $error("short clock high phase");
  clock_low_hold_a:
    assert property ($fell(sclk_in) |-> !sclk_in [*8]) else $error("short clock low phase");
  mosi_steady_a:
    assert property (sclk_in |-> $stable(mosi_in)) else $error("host data moved while high");
  miso_steady_a:
    assert property (miso_oe_in && sclk_in |-> $stable(miso_o_in))
      else $error("device data moved");
  drive_in_frame_a:
    assert property ($rose(miso_oe_in) |-> !cs_n_in && !sclk_in)
      else $error("device drove outside frame");
  release_idle_a:
    assert property (cs_n_in [*8] |-> !miso_oe_in && miso_in)
      else $error("device kept driving after frame");
  header_zeros_a:
    assert property ($rose(sclk_in) && bits_reg < 8'h05 |-> !mosi_in)
      else $error("header top bit set");
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Purpose: Drives whole frames from host registers into the device end.
// Assumes: Host and device share one clock and one reset.
// Notes:   Device state is read back through its register outputs.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import spcf_pkg::*;
  logic clk_in = 0, sys_rst_in = 1, wr_in = 0, rd_in = 0, halted = 1, win = 0;
  logic [3:0] addr_in = '0;
  logic [31:0] wdata_in = '0, rdata, rv;
  logic [1:0][23:0] cap = '0;
  logic [7:0] pa = '0, rb [8];
  logic [8:0] qa = '0;
  logic [21:0] pd, vol;
  logic [34:0] qd;
  logic [11:0] c1;
  logic [9:0] c2;
  logic [1:0][10:0] cs, ss;
  int bad_count = 0, comparisons = 0, cyc = 0;
  spcf_link_if link ();
  spcf_host spcf_host_i (.clk_in, .sys_rst_in, .link(link.host), .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out(rdata));
  spcf_device spcf_device_i (.clk_in, .sys_rst_in, .link(link.device), .core_halted_in(halted),
    .safeload_window_in(win), .cap_data_in(cap), .param_rd_addr_in(pa), .prog_rd_addr_in(qa),
    .param_rd_data_out(pd), .prog_rd_data_out(qd), .control_one_out(c1), .control_two_out(c2),
    .output_volume_out(vol), .capture_setup_out(cs), .serial_capture_setup_out(ss));
  spcf_checker spcf_checker_i (.clk_in, .sys_rst_in, .sclk_in(link.sclk), .cs_n_in(link.cs_n),
    .mosi_in(link.mosi), .miso_o_in(link.miso_o), .miso_oe_in(link.miso_oe),
    .miso_in(link.miso));
  // Clock and hang guard.
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One register bus cycle; read data is taken in the cycle after the strobe.
  task automatic bus(input logic [3:0] a, input logic [31:0] d, input logic w);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= w;
    rd_in <= !w;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic idle();
    int n;
    n = 0;
    do
    begin
      bus(HR_STAT, 32'h0, 1'b0);
      n++;
    end
    while (rv[0] !== 1'b0 && n < 500);
    if (n >= 500)
      bad_count++;
  endtask
  // Selects, sends the header, moves n bytes most significant first, deselects.
  task automatic frame(input logic rw, input logic [9:0] a, input int n, input logic [63:0] tx);
    bus(HR_CTRL, 32'h1, 1'b1);
    bus(HR_HDR, {21'h0, rw, a}, 1'b1);
    idle();
    for (int i = 0; i < n; i++)
    begin
      bus(HR_DATA, {24'h0, tx[8 * (n - 1 - i) +: 8]}, 1'b1);
      idle();
      bus(HR_DATA, 32'h0, 1'b0);
      rb[i] = rv[7:0];
    end
    bus(HR_CTRL, 32'h0, 1'b1);
    repeat (12) @(posedge clk_in);
  endtask
  initial
  begin
    logic [63:0] v, u;
    logic [7:0] t;
    v = $urandom(32'hcd92);
    cap <= 48'({$urandom, $urandom});
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    v = $urandom;
    frame(1'b0, ADDR_CTRL2, 2, v[9:0]);
    chk("control_two", c2, v[9:0]);
    frame(1'b0, ADDR_VOL, 3, v[21:0]);
    chk("volume", vol, v[21:0]);
    for (int k = 0; k < 4; k++)
    begin
      v = {$urandom, 2'(k)};
      frame(1'b0, ADDR_CAPSET + 10'(k), 2, v[10:0]);
      chk("setup", k < 2 ? cs[k] : ss[k - 2], v[10:0]);
    end
    $display("register writes done");
    v = $urandom;
    u = $urandom;
    t = 8'($urandom_range(254));
    frame(1'b0, {2'b00, t}, 6, {2'b00, v[21:0], 2'b00, u[21:0]});
    pa <= t;
    repeat (3) @(posedge clk_in);
    chk("param first", pd, v[21:0]);
    pa <= t + 8'h01;
    repeat (3) @(posedge clk_in);
    chk("param next", pd, u[21:0]);
    frame(1'b1, {2'b00, t + 8'h01}, 3, 64'h0);
    chk("param read", {rb[0], rb[1], rb[2]}, u[21:0]);
    frame(1'b0, {1'b1, u[8:0]}, 5, {u[31:29], v[31:0]});
    qa <= u[8:0];
    repeat (3) @(posedge clk_in);
    chk("program", qd, {u[31:29], v[31:0]});
    $display("memory test done");
    v = $urandom & 32'hfef;
    frame(1'b0, ADDR_CTRL1, 2, v[11:0]);
    chk("control_one", c1, v[11:0]);
    frame(1'b1, ADDR_CTRL1, 1, 64'h0);
    chk("status", rb[0], 8'h02);
    frame(1'b1, ADDR_CAPRD, 4, 64'h0);
    chk("readback", {rb[0], rb[1], rb[2], rb[3]}, {8'h00, cap[0]});
    halted <= 1'b0;
    v = $urandom;
    t = v[31:24];
    frame(1'b0, ADDR_SAFE, 4, {t, 2'b00, v[21:0]});
    frame(1'b0, ADDR_CTRL1, 2, 12'h010);
    win <= 1'b1;
    repeat (8) @(posedge clk_in);
    win <= 1'b0;
    repeat (20) @(posedge clk_in);
    frame(1'b1, ADDR_CTRL1, 1, 64'h0);
    chk("done set", rb[0], 8'h01);
    frame(1'b1, ADDR_CTRL1, 1, 64'h0);
    chk("done cleared", rb[0], 8'h00);
    pa <= t;
    repeat (3) @(posedge clk_in);
    chk("safeload", pd, v[21:0]);
    $display("status test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
